// *** bench/ircs_host_model.sv ***
// Behavioural I2C host that clocks bytes into the client
`timescale 1ns/1ps
`default_nettype none

module ircs_host_model (
    input  wire logic scl_oe_i,
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o,
    output logic      stall_o
);
    logic h_scl = 1'b1;
    logic h_sda = 1'b1;

    // Open-drain lines with pull-ups: low while either party pulls
    assign scl_o = h_scl & ~scl_oe_i;
    assign sda_o = h_sda & ~sda_oe_i;

    initial stall_o = 1'b0;

    // ==========================================================
    // Bus phases, 160 ns per SCL period
    // ==========================================================
    // Release SCL and wait, bounded, while the client stretches
    task automatic rise();
        int n;
        n = 0;
        h_scl = 1'b1;
        while (scl_o !== 1'b1 && n < 4000)
        begin
            #8;
            n++;
        end
        if (n == 4000)
            stall_o = 1'b1;
    endtask : rise

    // SDA falls while SCL is high
    task automatic start();
        #2; // Keep pin changes off the sampling edge
        h_sda = 1'b0;
        #80;
        h_scl = 1'b0;
        #40;
    endtask : start

    // SDA rises while SCL is high, then the bus rests idle
    task automatic stop();
        h_sda = 1'b0;
        #40;
        rise();
        #80;
        h_sda = 1'b1;
        #160;
    endtask : stop

    // Eight bits MSB first, then the ninth clock samples the answer
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            h_sda = b[i];
            #40;
            rise();
            #80;
            h_scl = 1'b0;
            #40;
        end
        h_sda = 1'b1;
        #40;
        rise();
        #40;
        ack = sda_o;
        #40;
        h_scl = 1'b0;
        #40;
    endtask : send_byte
endmodule : ircs_host_model

`default_nettype wire

// *** bench/ircs_rx_seq_tb.sv ***
// Self-checking testbench of the I2C client receive sequencer
`timescale 1ns/1ps
`default_nettype none

module ircs_rx_seq_tb;
    import ircs_pkg::*;

    localparam logic [7:0] OWN_HI = 8'hf6;
    localparam logic [7:0] OWN_LO = 8'h3c;

    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    logic       scl, sda, scl_oe, sda_oe, stall;
    logic       ten = 1'b0, str_en = 1'b0, ahold = 1'b0, dhold = 1'b0;
    logic       start_ie = 1'b0, stop_ie = 1'b0, ackv = 1'b0;
    logic       own_wr = 1'b0, rel_set = 1'b0, ev_clr = 1'b0;
    logic       ov_clr = 1'b0, rx_rdy = 1'b0, drain = 1'b0;
    logic [7:0] own = 8'ha0, mask = 8'hff, rx_data;
    logic       ev, s_seen, p_seen, ack_ph, rel, pend, bfull, ovf, rx_vld;
    int         fail_count = 0, total_checks = 0;
    int         ev_cnt = 0, ph_cnt = 0, rel_cnt = 0;
    logic [31:0] rng = 32'hf630;
    logic [7:0] exp_q[$];

    always #4 mclk = ~mclk;

    ircs_rx_seq u_dut (
        .MCLK_I(mclk), .SRST_I(srst), .SCL_I(scl), .SDA_I(sda),
        .SCL_O(), .SCL_OE_O(scl_oe), .SDA_O(), .SDA_OE_O(sda_oe),
        .TEN_BIT_I(ten), .STRETCH_EN_I(str_en), .ADDR_HOLD_EN_I(ahold),
        .DATA_HOLD_EN_I(dhold), .START_IRQ_EN_I(start_ie),
        .STOP_IRQ_EN_I(stop_ie), .ACK_VALUE_I(ackv), .OWN_ADDR_I(own),
        .OWN_ADDR_WR_I(own_wr), .ADDR_MASK_I(mask),
        .CLK_RELEASE_SET_I(rel_set), .EVENT_CLR_I(ev_clr),
        .OVERFLOW_CLR_I(ov_clr), .EVENT_FLAG_O(ev), .START_SEEN_O(s_seen),
        .STOP_SEEN_O(p_seen), .ACK_PHASE_O(ack_ph), .CLK_RELEASE_O(rel),
        .LOW_BYTE_PEND_O(pend), .BUFFER_FULL_O(bfull), .OVERFLOW_O(ovf),
        .RX_DATA_O(rx_data), .RX_VALID_O(rx_vld), .RX_READY_I(rx_rdy)
    );

    ircs_host_model u_host (
        .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda),
        .stall_o(stall)
    );

    // ==========================================================
    // Checking and reporting
    // ==========================================================
    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flag

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    function automatic logic [7:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction : rnd

    // ==========================================================
    // Software model: clears events, releases SCL, reloads address
    // ==========================================================
    always @(posedge mclk)
    begin
        ev_clr  <= 1'b0;
        rel_set <= 1'b0;
        own_wr  <= 1'b0;
        rx_rdy  <= 1'b0;
        if (ev === 1'b1 && !ev_clr)
        begin
            ev_cnt++;
            ph_cnt += (ack_ph === 1'b1) ? 1 : 0;
            ev_clr <= 1'b1;
        end
        if (rel === 1'b0 && !rel_set)
        begin
            rel_cnt++;
            rel_set <= 1'b1;
        end
        // Address is rewritten only once the ack bit is over
        if (pend === 1'b1 && sda_oe === 1'b0 && !own_wr)
        begin
            own    <= (own == OWN_HI) ? OWN_LO : OWN_HI;
            own_wr <= 1'b1;
        end
        else if (ten === 1'b1 && own == 8'ha0)
            own <= OWN_HI; // Load the high address for 10-bit mode
        if (drain && rx_vld === 1'b1 && !rx_rdy)
        begin
            chk_val(rx_data, exp_q.pop_front());
            rx_rdy <= 1'b1;
        end
    end

    // ==========================================================
    // Stimulus helpers
    // ==========================================================
    // Bits: ten, stretch, addr hold, data hold, start ev, stop ev, nack, drain
    task automatic cfg(input logic [7:0] v);
        @(posedge mclk);
        {ten, str_en, ahold, dhold, start_ie, stop_ie, ackv, drain} <= v;
        ev_cnt  = 0;
        ph_cnt  = 0;
        rel_cnt = 0;
    endtask : cfg

    task automatic xfer(input logic [7:0] b, input logic sda_exp,
                        input logic push);
        logic got;
        if (push)
            exp_q.push_back(b);
        u_host.send_byte(b, got);
        chk_flag(got, sda_exp);
    endtask : xfer

    // Bounded wait for the buffer to drain and events to be taken
    task automatic settle();
        int n;
        n = 0;
        while ((rx_vld !== 1'b0 || ev !== 1'b0) && n < 500)
        begin
            @(posedge mclk);
            n++;
        end
        repeat (4) @(posedge mclk);
        if (n == 500 || stall === 1'b1)
        begin
            fail_count++;
            report_and_stop();
        end
    endtask : settle

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial
    begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk_flag(rel, CKP_RST);
        // 7-bit write, stretching on, start event on
        cfg(8'b0100_1001);
        u_host.start();
        chk_flag(s_seen, 1'b1);
        xfer(8'ha0, 1'b0, 1'b1);
        repeat (3) xfer(rnd(), 1'b0, 1'b1);
        u_host.stop();
        settle();
        chk_flag(p_seen, 1'b1);
        chk_val(ev_cnt, 5);
        chk_val(rel_cnt, 4);
        // Masked match, then a refused address; stop events on
        cfg(8'b0000_0101);
        mask <= 8'hf7;
        u_host.start();
        xfer(8'ha8, 1'b0, 1'b1);
        u_host.stop();
        u_host.start();
        xfer(8'h52, 1'b1, 1'b0);
        u_host.stop();
        settle();
        chk_val(ev_cnt, 3);
        chk_val(rel_cnt, 0);
        // Address and data hold with stretching, last byte refused
        cfg(8'b0111_0001);
        mask <= 8'hff;
        u_host.start();
        xfer(8'ha0, 1'b0, 1'b1);
        xfer(rnd(), 1'b0, 1'b1);
        @(posedge mclk);
        ackv <= 1'b1;
        #2;
        xfer(rnd(), 1'b1, 1'b1);
        u_host.stop();
        settle();
        chk_val(ev_cnt, 5);
        chk_val(ph_cnt, 3);
        chk_val(rel_cnt, 5);
        // Buffer left full: third byte is refused
        cfg(8'b0000_0000);
        u_host.start();
        xfer(8'ha0, 1'b0, 1'b1);
        xfer(rnd(), 1'b0, 1'b1);
        chk_flag(bfull, 1'b1);
        xfer(rnd(), 1'b1, 1'b0);
        u_host.stop();
        chk_flag(ovf, 1'b1);
        cfg(8'b0000_0001);
        settle();
        chk_flag(bfull, 1'b0);
        ov_clr <= 1'b1;
        @(posedge mclk);
        ov_clr <= 1'b0;
        repeat (2) @(posedge mclk);
        chk_flag(ovf, 1'b0);
        // 10-bit write with stretching, then a low byte mismatch
        cfg(8'b1100_0001);
        u_host.start();
        xfer(OWN_HI, 1'b0, 1'b1);
        xfer(OWN_LO, 1'b0, 1'b1);
        rel_cnt = 0;
        xfer(rnd(), 1'b0, 1'b1);
        u_host.stop();
        settle();
        chk_val(rel_cnt, 1);
        chk_val(ev_cnt, 3);
        cfg(8'b1100_0001);
        u_host.start();
        xfer(OWN_HI, 1'b0, 1'b1);
        xfer(OWN_LO ^ 8'h01, 1'b1, 1'b0);
        u_host.stop();
        settle();
        chk_val(ev_cnt, 2);
        chk_val(own, OWN_HI);
        report_and_stop();
    end
endmodule : ircs_rx_seq_tb

`default_nettype wire

// *** hdl/ircs_buf2.sv ***
// Small receive buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module ircs_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int             AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0]  LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]    FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    // Honest full and empty from the fill count
    assign in_ready_o  = (cnt_ff != FULL);
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o  = mem_ff[rd_ff];

    // Storage write
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_ff[wr_ff] <= in_data_i;
    end

    // Pointers and count
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ff <= (wr_ff == LAST) ? '0 : wr_ff + 1'b1;
            if (pop)
                rd_ff <= (rd_ff == LAST) ? '0 : rd_ff + 1'b1;
            if (push && !pop)
                cnt_ff <= cnt_ff + 1'b1;
            else if (pop && !push)
                cnt_ff <= cnt_ff - 1'b1;
        end
    end
endmodule : ircs_buf2

`default_nettype wire

// *** hdl/ircs_rx_seq.sv ***
// I2C client receive sequencer: address match, ack, stretch, hold
`timescale 1ns/1ps
`default_nettype none

module ircs_rx_seq (
    input  wire logic                          MCLK_I,
    input  wire logic                          SRST_I,
    input  wire logic                          SCL_I,
    input  wire logic                          SDA_I,
    output logic                               SCL_O,
    output logic                               SCL_OE_O,
    output logic                               SDA_O,
    output logic                               SDA_OE_O,
    input  wire logic                          TEN_BIT_I,
    input  wire logic                          STRETCH_EN_I,
    input  wire logic                          ADDR_HOLD_EN_I,
    input  wire logic                          DATA_HOLD_EN_I,
    input  wire logic                          START_IRQ_EN_I,
    input  wire logic                          STOP_IRQ_EN_I,
    input  wire logic                          ACK_VALUE_I,
    input  wire logic [ircs_pkg::BYTE_W-1:0]   OWN_ADDR_I,
    input  wire logic                          OWN_ADDR_WR_I,
    input  wire logic [ircs_pkg::BYTE_W-1:0]   ADDR_MASK_I,
    input  wire logic                          CLK_RELEASE_SET_I,
    input  wire logic                          EVENT_CLR_I,
    input  wire logic                          OVERFLOW_CLR_I,
    output logic                               EVENT_FLAG_O,
    output logic                               START_SEEN_O,
    output logic                               STOP_SEEN_O,
    output logic                               ACK_PHASE_O,
    output logic                               CLK_RELEASE_O,
    output logic                               LOW_BYTE_PEND_O,
    output logic                               BUFFER_FULL_O,
    output logic                               OVERFLOW_O,
    output logic [ircs_pkg::BYTE_W-1:0]        RX_DATA_O,
    output logic                               RX_VALID_O,
    input  wire logic                          RX_READY_I
);
    import ircs_pkg::*;

    // ==========================================================
    // Declarations
    logic [1:0]        scl_sync_ff;
    logic [1:0]        sda_sync_ff;
    logic              scl_prev_ff;
    logic              sda_prev_ff;
    ircs_state_t       state_ff;
    ircs_state_t       nxt_state;
    logic [3:0]        cnt_ff;
    logic [BYTE_W-1:0] shift_ff;
    logic              held_ff;
    logic              acked_ff;
    logic              sda_drive_ff;
    logic              scl_hold_ff;
    logic              ack_phase_ff;
    logic              lo_miss_ff;
    logic              ua_ff;
    logic              ckp_ff;
    logic              event_ff;
    logic              start_seen_ff;
    logic              stop_seen_ff;
    logic              ovf_ff;
    logic              buf_in_ready;

    // ==========================================================
    // Line synchronisers and bus conditions
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            scl_sync_ff <= SYNC_IDLE;
            sda_sync_ff <= SYNC_IDLE;
            scl_prev_ff <= LINE_IDLE;
            sda_prev_ff <= LINE_IDLE;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[0], SCL_I}; // RULE25
            sda_sync_ff <= {sda_sync_ff[0], SDA_I}; // RULE25
            scl_prev_ff <= scl_sync_ff[1];
            sda_prev_ff <= sda_sync_ff[1];
        end
    end

    // Edges and start/stop as SDA moves while SCL stays high
    wire scl_s     = scl_sync_ff[1];
    wire sda_s     = sda_sync_ff[1];
    wire scl_rise  = scl_s & ~scl_prev_ff;
    wire scl_fall  = ~scl_s & scl_prev_ff;
    wire scl_steady = scl_s & scl_prev_ff;
    wire start_det = scl_steady & sda_prev_ff & ~sda_s; // RULE25
    wire stop_det  = scl_steady & ~sda_prev_ff & sda_s; // RULE25

    // ==========================================================
    // Byte phase decode
    wire active  = (state_ff != ST_IDLE) && (state_ff != ST_SKIP);
    wire is_addr = (state_ff == ST_ADDR_HI) || (state_ff == ST_ADDR_LO);
    wire fall8   = scl_fall && (cnt_ff == BYTE_BITS) && active;
    wire fall9   = scl_fall && (cnt_ff == ACK_BIT) && active;

    // Address compare, mask zeros are don't-cares except in the 10-bit high byte
    wire [6:0] a7_diff = shift_ff[7:1] ^ OWN_ADDR_I[7:1];
    wire a7_match = ~|(a7_diff & ADDR_MASK_I[7:1]) & ~shift_ff[0]; // RULE24
    wire hi_match = (shift_ff[7:3] == TEN_HI_PAT)
                  & (shift_ff[2:1] == OWN_ADDR_I[2:1])
                  & ~shift_ff[0]; // RULE22
    wire lo_match = ~|((shift_ff ^ OWN_ADDR_I) & ADDR_MASK_I); // RULE24
    wire hi_byte  = TEN_BIT_I ? hi_match : a7_match;
    wire byte_match = (state_ff == ST_ADDR_HI) ? hi_byte :
                      (state_ff == ST_ADDR_LO) ? lo_match : 1'b1;

    // Acknowledge and hold decisions at the eighth fall
    wire room      = buf_in_ready & ~ovf_ff; // RULE23
    wire ack_ok    = byte_match & room;
    wire hold_sel  = is_addr ? ADDR_HOLD_EN_I : DATA_HOLD_EN_I;
    wire hold_now  = fall8 & ack_ok & hold_sel; // RULE8 RULE13
    wire push      = fall8 & ack_ok;
    wire ovf_set   = fall8 & byte_match & ~buf_in_ready; // RULE23
    wire hold_mode = ADDR_HOLD_EN_I | DATA_HOLD_EN_I;
    wire rel_ack   = held_ff & ckp_ff;

    // Ninth-fall effects
    wire lo_phase  = (state_ff == ST_ADDR_LO);
    wire hi_ten    = (state_ff == ST_ADDR_HI) & TEN_BIT_I & acked_ff;
    wire ua_set    = fall9 & (hi_ten | lo_phase); // RULE15 RULE17 RULE19
    wire evt_ack   = fall9 & (acked_ff | lo_miss_ff); // RULE1 RULE11
    wire stretch_clr = fall9 & acked_ff & STRETCH_EN_I & ~ua_set; // RULE12
    wire ckp_clr   = hold_now | stretch_clr;
    wire start_evt = start_det & START_IRQ_EN_I; // RULE3
    wire stop_evt  = stop_det & STOP_IRQ_EN_I; // RULE14
    wire event_set = start_evt | stop_evt | hold_now | evt_ack;
    wire want_hold = ~ckp_ff | ua_ff | held_ff; // RULE16

    // ==========================================================
    // Sequencer state
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_ADDR_HI:
                if (fall8 && !byte_match)
                    nxt_state = ST_SKIP;
                else if (fall9)
                    nxt_state = !acked_ff ? ST_SKIP :
                                TEN_BIT_I ? ST_ADDR_LO : ST_DATA;
            ST_ADDR_LO:
                if (fall9)
                    nxt_state = acked_ff ? ST_DATA : ST_SKIP;
            ST_DATA:
                if (fall9 && !acked_ff)
                    nxt_state = ST_SKIP;
            ST_IDLE,
            ST_SKIP:
                nxt_state = state_ff;
            default:
                nxt_state = ST_IDLE;
        endcase
        if (start_det)
            nxt_state = ST_ADDR_HI;
        if (stop_det)
            nxt_state = ST_IDLE; // RULE7
    end

    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Bit counter and shift register, sampled on SCL rise
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I || start_det || fall9)
            cnt_ff <= CNT_ZERO;
        else if (scl_rise && cnt_ff != ACK_BIT)
            cnt_ff <= cnt_ff + 1'b1;
    end

    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
            shift_ff <= BYTE_RST;
        else if (scl_rise && cnt_ff < BYTE_BITS)
            shift_ff <= {shift_ff[BYTE_W-2:0], sda_s};
    end

    // ==========================================================
    // Acknowledge bit drive
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I || start_det || stop_det || fall9)
        begin
            held_ff      <= 1'b0;
            acked_ff     <= 1'b0;
            sda_drive_ff <= 1'b0;
        end
        else if (fall8)
        begin
            held_ff      <= hold_now;
            acked_ff     <= ack_ok & ~hold_sel; // RULE4 RULE6
            sda_drive_ff <= ack_ok & ~hold_sel; // RULE4 RULE6
        end
        else if (rel_ack)
        begin
            held_ff      <= 1'b0;
            acked_ff     <= ~ACK_VALUE_I; // RULE10
            sda_drive_ff <= ~ACK_VALUE_I; // RULE10
        end
    end

    // Ack phase status and low byte mismatch marker
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I || start_det || stop_det || fall9)
        begin
            ack_phase_ff <= 1'b0;
            lo_miss_ff   <= 1'b0;
        end
        else if (fall8)
        begin
            ack_phase_ff <= hold_mode & byte_match; // RULE9
            lo_miss_ff   <= lo_phase & ~lo_match; // RULE19
        end
    end

    // SCL is only grabbed once it is already seen low
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
            scl_hold_ff <= 1'b0;
        else
            scl_hold_ff <= want_hold & (~scl_s | scl_hold_ff); // RULE2
    end

    // ==========================================================
    // Software visible flags
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
            ckp_ff <= CKP_RST;
        else if (ckp_clr)
            ckp_ff <= 1'b0; // RULE8 RULE13 RULE20
        else if (CLK_RELEASE_SET_I)
            ckp_ff <= 1'b1;
    end

    // Hardware set wins over software clear
    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            event_ff <= 1'b0;
            ua_ff    <= 1'b0;
            ovf_ff   <= 1'b0;
        end
        else
        begin
            event_ff <= event_set | (event_ff & ~EVENT_CLR_I);
            ua_ff    <= ua_set | (ua_ff & ~OWN_ADDR_WR_I); // RULE16
            ovf_ff   <= ovf_set | (ovf_ff & ~OVERFLOW_CLR_I);
        end
    end

    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            start_seen_ff <= 1'b0;
            stop_seen_ff  <= 1'b0;
        end
        else if (start_det)
        begin
            start_seen_ff <= 1'b1; // RULE3
            stop_seen_ff  <= 1'b0;
        end
        else if (stop_det)
        begin
            start_seen_ff <= 1'b0;
            stop_seen_ff  <= 1'b1; // RULE7
        end
    end

    // ==========================================================
    // Receive buffer, a stalled reader makes later bytes NACK
    ircs_buf2 #(
        .WIDTH (BYTE_W),
        .DEPTH (2)
    ) u_rx_buf (
        .clk_i       (MCLK_I),
        .srst_i      (SRST_I),
        .in_data_i   (shift_ff),
        .in_valid_i  (push),
        .in_ready_o  (buf_in_ready),
        .out_data_o  (RX_DATA_O),
        .out_valid_o (RX_VALID_O),
        .out_ready_i (RX_READY_I)
    );

    // ==========================================================
    // Outputs
    assign SCL_O           = 1'b0;
    assign SCL_OE_O        = scl_hold_ff;
    assign SDA_O           = 1'b0;
    assign SDA_OE_O        = sda_drive_ff;
    assign EVENT_FLAG_O    = event_ff;
    assign START_SEEN_O    = start_seen_ff;
    assign STOP_SEEN_O     = stop_seen_ff;
    assign ACK_PHASE_O     = ack_phase_ff;
    assign CLK_RELEASE_O   = ckp_ff;
    assign LOW_BYTE_PEND_O = ua_ff;
    assign BUFFER_FULL_O   = ~buf_in_ready; // RULE5
    assign OVERFLOW_O      = ovf_ff;

    // ==========================================================
    // Assertions
    default clocking a_clk @(posedge MCLK_I);
    endclocking
    default disable iff (SRST_I);

    a_start_flag: // RULE3
        assert property (start_det |=> start_seen_ff && event_ff == (
            $past(START_IRQ_EN_I) || $past(event_ff) && !$past(EVENT_CLR_I)))
        else $error("start flag or event wrong");

    a_stop_idle: // RULE7
        assert property (stop_det |=> state_ff == ST_IDLE && stop_seen_ff)
        else $error("stop did not idle the bus");

    a_stop_quiet: // RULE14
        assert property (stop_det && !STOP_IRQ_EN_I && !event_ff
                         |=> !event_ff)
        else $error("stop raised event while disabled");

    a_full_nack: // RULE23
        assert property (fall8 && (!buf_in_ready || ovf_ff)
                         |=> !sda_drive_ff && !held_ff)
        else $error("ack given with buffer full");

    a_hold_stretch: // RULE8
        assert property (fall8 && ack_ok && hold_sel
                         |=> !ckp_ff && ack_phase_ff && event_ff
                         ##1 scl_hold_ff)
        else $error("hold did not stretch");

    a_ack_value: // RULE10
        assert property (rel_ack |=> sda_drive_ff == !$past(ACK_VALUE_I)
                         ##1 !scl_hold_ff || !ckp_ff || ua_ff)
        else $error("held ack not taken from ack value");

    a_nack_quiet: // RULE11
        assert property (fall9 && !acked_ff && !lo_miss_ff && !event_ff
                         |=> !event_ff)
        else $error("event after nack");

    a_ack_event: // RULE1
        assert property (fall9 && acked_ff |=> event_ff && !sda_drive_ff)
        else $error("acked byte gave no event");

    a_stretch_clr: // RULE12
        assert property (fall9 && acked_ff && STRETCH_EN_I && !ua_set
                         |=> !ckp_ff ##1 scl_hold_ff)
        else $error("no stretch after ack");

    a_ua_stretch: // RULE16
        assert property (ua_ff && !scl_s |=> scl_hold_ff)
        else $error("update flag did not hold SCL");
endmodule : ircs_rx_seq

`default_nettype wire

// *** pkg/ircs_pkg.sv ***
// Constants and state type of the I2C client receive sequencer
// Overview of operation
// RULE1 - Each transferred data byte raises event flag
// RULE2 - Stretch enable holds SCL after each byte
// RULE3 - Start sets start bit, event if enabled
// RULE4 - Matching 7-bit write address is acknowledged
// RULE5 - Reading receive buffer clears buffer full
// RULE6 - Each written data byte is acknowledged
// RULE7 - Stop sets stop bit, bus idle
// RULE8 - Address hold stretches after eighth fall
// RULE9 - Ack phase bit marks event timing
// RULE10 - Held byte acknowledged from ack value bit
// RULE11 - Ninth fall raises event only after ACK; code also raises it at the ninth fall after a mismatched 10-bit low byte
// RULE12 - Hold with stretch stretches after ack
// RULE13 - Data hold stretches after eighth fall
// RULE14 - Stop without enable raises no event
// RULE15 - Matching 10-bit high byte sets update flag
// RULE16 - Own address write releases update stretch
// RULE17 - Matching low byte sets update flag again
// RULE18 - Software writes address only after ack
// RULE19 - Mismatched low byte still flags, no data
// RULE20 - 10-bit data with stretch clears release bit
// RULE21 - Software reloads high address after low
// RULE22 - High byte compares 11110, A9, A8, 0
// RULE23 - Full buffer or overflow withholds ACK
// RULE24 - Zero mask bits are address don't-cares
// RULE25 - Lines synchronised, start/stop while SCL high
`default_nettype none

package ircs_pkg;
    localparam int          BYTE_W     = 8;
    localparam logic [3:0]  CNT_ZERO   = 4'h0;
    localparam logic [3:0]  BYTE_BITS  = 4'h8;
    localparam logic [3:0]  ACK_BIT    = 4'h9;
    localparam logic [4:0]  TEN_HI_PAT = 5'h1e;
    localparam logic [1:0]  SYNC_IDLE  = 2'h3;
    localparam logic        LINE_IDLE  = 1'b1;
    localparam logic        CKP_RST    = 1'b1;
    localparam logic [7:0]  BYTE_RST   = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_DATA,
        ST_SKIP
    } ircs_state_t;
endpackage : ircs_pkg

`default_nettype wire
